// file: hdl/octet_dqdb_end.sv
// Purpose: access layer end relaying octets between the two access points
// Assumes: indications paced by the physical layer
// Notes: one request per indication, on the opposite point, next cycle
`timescale 1ns/1ps
`include "octet_port_defines.svh"
module octet_dqdb_end (
    input wire logic clk,
    input wire logic nrst,
    octet_sap_if.dqdb sap_a,
    octet_sap_if.dqdb sap_b,
    input wire logic [15:0] set_mask,
    output logic [1:0] rx_seen,
    output logic [1:0] slot_err
);
    logic [1:0] req_stb_r;
    logic [7:0] req_octet_r [2];
    octet_port_pkg::octet_kind_type req_kind_r [2];
    logic [1:0] req_valid_r;
    logic [1:0] ind_stb;
    logic [7:0] ind_octet [2];
    octet_port_pkg::octet_kind_type ind_kind [2];
    logic [1:0] ind_valid;

    assign ind_stb = {sap_b.ind_stb, sap_a.ind_stb};
    assign ind_octet[0] = sap_a.ind_octet;
    assign ind_octet[1] = sap_b.ind_octet;
    assign ind_kind[0] = sap_a.ind_kind;
    assign ind_kind[1] = sap_b.ind_kind;
    assign ind_valid = {sap_b.ind_valid, sap_a.ind_valid};
    assign sap_a.req_stb = req_stb_r[0];
    assign sap_a.req_octet = req_octet_r[0];
    assign sap_a.req_kind = req_kind_r[0];
    assign sap_a.req_valid = req_valid_r[0];
    assign sap_b.req_stb = req_stb_r[1];
    assign sap_b.req_octet = req_octet_r[1];
    assign sap_b.req_kind = req_kind_r[1];
    assign sap_b.req_valid = req_valid_r[1];

    // ------------------------------------------------------------
    // relay: output point o is fed from input point 1-o
    // ------------------------------------------------------------
    genvar o;
    generate
        for (o = 0; o < 2; o++) begin : g_relay
            logic [5:0] data_cnt_r;
            wire in_stb = ind_stb[1-o];
            wire is_slot = ind_kind[1-o] != octet_port_pkg::OCT_MGMT;
            // slot bits may only be raised; management passes untouched
            wire [7:0] relayed = is_slot ?
                (ind_octet[1-o] | set_mask[8*o +: 8]) : ind_octet[1-o];
            wire is_start = ind_kind[1-o] == octet_port_pkg::OCT_SLOT_START;
            wire is_data = ind_kind[1-o] == octet_port_pkg::OCT_SLOT_DATA;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    req_stb_r[o] <= 1'b0;
                    req_octet_r[o] <= 8'h00;
                    req_kind_r[o] <= octet_port_pkg::OCT_SLOT_START;
                    req_valid_r[o] <= 1'b0;
                    data_cnt_r <= 6'h0;
                    slot_err[o] <= 1'b0;
                    rx_seen[o] <= 1'b0;
                end else begin
                    req_stb_r[o] <= in_stb;
                    rx_seen[o] <= in_stb;
                    if (in_stb) begin
                        req_octet_r[o] <= relayed;
                        req_kind_r[o] <= ind_kind[1-o];
                        req_valid_r[o] <= ind_valid[1-o];
                    end
                    // count data octets after each start to watch the slot length
                    slot_err[o] <= in_stb && is_start &&
                        (data_cnt_r != 6'(`SLOT_DATA_COUNT));
                    if (in_stb && is_start) begin
                        data_cnt_r <= 6'h0;
                    end else if (in_stb && is_data) begin
                        data_cnt_r <= data_cnt_r + 6'h1;
                    end
                end
            end
        end
    endgenerate
endmodule

// file: hdl/octet_pacer.sv
// Purpose: octet timing source for one access point
// Assumes: frame of FRAME_CYCLES cycles; octets every GAP cycles
// Notes: emits slots of a start and 52 slot data, and a few management octets per frame
`timescale 1ns/1ps
`include "octet_port_defines.svh"
module octet_pacer #(
    parameter int FRAME_CYCLES = `FRAME_CYCLES,
    parameter int GAP = `OCTET_GAP_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    output logic tick,
    output octet_port_pkg::octet_kind_type kind
);
    logic [31:0] frame_r;
    logic [7:0] gap_r;
    logic [5:0] pos_r;
    logic [2:0] mgmt_r;
    wire frame_end = (frame_r == 32'(FRAME_CYCLES - 1));
    wire gap_end = (gap_r == 8'(GAP - 1));
    // management octets lead each frame, then slots fill the rest
    wire in_mgmt = (mgmt_r != 3'h0);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_r <= 32'h0;
            gap_r <= 8'h0;
            pos_r <= 6'h0;
            mgmt_r <= 3'(`MGMT_PER_FRAME);
        end else begin
            frame_r <= frame_end ? 32'h0 : frame_r + 32'h1;
            gap_r <= (gap_end || frame_end) ? 8'h0 : gap_r + 8'h1;
            if (frame_end) begin
                mgmt_r <= 3'(`MGMT_PER_FRAME);
                pos_r <= 6'h0;
            end else if (gap_end && in_mgmt) begin
                mgmt_r <= mgmt_r - 3'h1;
            end else if (gap_end) begin
                pos_r <= (pos_r == 6'(`SLOT_DATA_COUNT)) ? 6'h0 : pos_r + 6'h1;
            end
        end
    end
    // a slot still open at frame end is cut short; a gap end on the last cycle of a frame gives no tick
    assign tick = gap_end && !frame_end;
    assign kind = in_mgmt ? octet_port_pkg::OCT_MGMT :
        (pos_r == 6'h0) ? octet_port_pkg::OCT_SLOT_START : octet_port_pkg::OCT_SLOT_DATA;
endmodule

// file: hdl/octet_phy_end.sv
// Purpose: physical layer end offering two octet service access points
// Assumes: link receive strobes are already on the node clock
// Notes: index 0 of every per-point vector is point A, index 1 is point B
`timescale 1ns/1ps
`include "octet_port_defines.svh"
module octet_phy_end #(
    parameter int FRAME_CYCLES = `FRAME_CYCLES,
    parameter int GAP = `OCTET_GAP_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    octet_sap_if.phy sap_a,
    octet_sap_if.phy sap_b,
    input wire logic hob_capable,
    input wire logic [1:0] link_up,
    input wire logic [1:0] rx_stb,
    input wire logic [15:0] rx_octet,
    input wire logic [3:0] rx_kind,
    input wire logic [1:0] rx_valid,
    output logic [1:0] tx_stb,
    output logic [15:0] tx_octet,
    output logic [3:0] tx_kind,
    output logic [1:0] tx_valid,
    output logic [1:0] tx_dropped
);
    logic [1:0] tick;
    octet_port_pkg::octet_kind_type pace_kind [2];
    logic [1:0] ind_stb_r;
    logic [7:0] ind_octet_r [2];
    octet_port_pkg::octet_kind_type ind_kind_r [2];
    logic [1:0] ind_valid_r;
    logic [1:0] req_stb;
    logic [7:0] req_octet [2];
    octet_port_pkg::octet_kind_type req_kind [2];
    logic [1:0] req_valid;

    // ------------------------------------------------------------
    // access point wiring: index 0 is point A, index 1 is point B
    // ------------------------------------------------------------
    assign sap_a.ind_stb = ind_stb_r[0];
    assign sap_a.ind_octet = ind_octet_r[0];
    assign sap_a.ind_kind = ind_kind_r[0];
    assign sap_a.ind_valid = ind_valid_r[0];
    assign sap_b.ind_stb = ind_stb_r[1];
    assign sap_b.ind_octet = ind_octet_r[1];
    assign sap_b.ind_kind = ind_kind_r[1];
    assign sap_b.ind_valid = ind_valid_r[1];
    assign req_stb = {sap_b.req_stb, sap_a.req_stb};
    assign req_octet[0] = sap_a.req_octet;
    assign req_octet[1] = sap_b.req_octet;
    assign req_kind[0] = sap_a.req_kind;
    assign req_kind[1] = sap_b.req_kind;
    assign req_valid = {sap_b.req_valid, sap_a.req_valid};

    // ------------------------------------------------------------
    // per access point logic
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_sap
            logic [1:0] up_sync_r;
            logic up;
            logic from_peer;
            logic local_empty;
            logic send_ok;
            logic do_send;
            logic [7:0] rx_octet_i;
            octet_port_pkg::octet_kind_type rx_kind_i;
            logic ind_stb_nxt;
            logic [7:0] ind_octet_nxt;
            octet_port_pkg::octet_kind_type ind_kind_nxt;
            logic ind_valid_nxt;
            logic [7:0] tx_octet_nxt;
            logic [1:0] tx_kind_nxt;
            logic tx_valid_nxt;
            logic drop_nxt;

            // ------------------------------------------------------------
            // timing source
            // ------------------------------------------------------------
            // each point paces itself, so a dead link still yields frame timing
            octet_pacer #(.FRAME_CYCLES(FRAME_CYCLES), .GAP(GAP)) u_pace (
                .clk(clk),
                .nrst(nrst),
                .tick(tick[i]),
                .kind(pace_kind[i])
            );

            // ------------------------------------------------------------
            // link status
            // ------------------------------------------------------------
            // link status comes from the line side, so it is synchronised
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    up_sync_r <= 2'h0;
                end else begin
                    up_sync_r <= {up_sync_r[0], link_up[i]};
                end
            end
            assign up = up_sync_r[1];

            // ------------------------------------------------------------
            // indication path
            // ------------------------------------------------------------
            assign rx_octet_i = rx_octet[8*i +: 8];
            assign rx_kind_i = octet_port_pkg::octet_kind_type'(rx_kind[2*i +: 2]);
            assign from_peer = up && rx_stb[i];
            // a head of bus without a live link still needs slot timing
            assign local_empty = !up && hob_capable && tick[i];
            assign ind_stb_nxt = from_peer || local_empty;
            assign ind_octet_nxt = from_peer ? rx_octet_i :
                local_empty ? `EMPTY_OCTET : ind_octet_r[i];
            assign ind_kind_nxt = from_peer ? rx_kind_i :
                local_empty ? pace_kind[i] : ind_kind_r[i];
            // empties are marked valid: they carry timing, not content
            assign ind_valid_nxt = from_peer ? rx_valid[i] :
                local_empty ? 1'b1 : ind_valid_r[i];

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ind_stb_r[i] <= 1'b0;
                end else begin
                    ind_stb_r[i] <= ind_stb_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ind_octet_r[i] <= 8'h00;
                end else begin
                    ind_octet_r[i] <= ind_octet_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ind_kind_r[i] <= octet_port_pkg::OCT_SLOT_START;
                end else begin
                    ind_kind_r[i] <= ind_kind_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ind_valid_r[i] <= 1'b0;
                end else begin
                    ind_valid_r[i] <= ind_valid_nxt;
                end
            end

            // ------------------------------------------------------------
            // request path
            // ------------------------------------------------------------
            assign send_ok = up || (req_kind[i] == octet_port_pkg::OCT_MGMT);
            assign do_send = req_stb[i] && send_ok;
            assign tx_octet_nxt = do_send ? req_octet[i] : tx_octet[8*i +: 8];
            assign tx_kind_nxt = do_send ? 2'(req_kind[i]) : tx_kind[2*i +: 2];
            assign tx_valid_nxt = do_send ? req_valid[i] : tx_valid[i];
            // slot octets on a down link are discarded and flagged
            assign drop_nxt = req_stb[i] && !send_ok;

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tx_stb[i] <= 1'b0;
                end else begin
                    tx_stb[i] <= do_send;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tx_octet[8*i +: 8] <= 8'h00;
                end else begin
                    tx_octet[8*i +: 8] <= tx_octet_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tx_kind[2*i +: 2] <= 2'h0;
                end else begin
                    tx_kind[2*i +: 2] <= tx_kind_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tx_valid[i] <= 1'b0;
                end else begin
                    tx_valid[i] <= tx_valid_nxt;
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tx_dropped[i] <= 1'b0;
                end else begin
                    tx_dropped[i] <= drop_nxt;
                end
            end
        end
    endgenerate
endmodule

// file: hdl/octet_port_defines.svh
// Purpose: constants shared by both ends of the octet service port
// Assumes: 200 MHz node clock
// Notes: timing counts derived from printed figures
`ifndef OCTET_PORT_DEFINES_SVH
`define OCTET_PORT_DEFINES_SVH
`define CLK_PERIOD_PS 5000
`define FRAME_TIME_US 125
`define FRAME_CYCLES ((`FRAME_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define SLOT_DATA_COUNT 52
`define OCTET_GAP_CYCLES 8
`define EMPTY_OCTET 8'h00
`define MGMT_PER_FRAME 4
`endif

// file: hdl/octet_port_pkg.sv
// Purpose: types for the octet service port
// Assumes: nothing
// Notes: type codes are shared by both ends
package octet_port_pkg;
    typedef enum logic [1:0] {
        OCT_SLOT_START = 2'h0,
        OCT_SLOT_DATA = 2'h1,
        OCT_MGMT = 2'h2
    } octet_kind_type;
endpackage

// file: hdl/octet_sap_if.sv
// Purpose: one octet service access point between physical and access layers
// Assumes: single node clock
// Notes: indication flows up, request flows down
`timescale 1ns/1ps
interface octet_sap_if;
    logic ind_stb;
    logic [7:0] ind_octet;
    octet_port_pkg::octet_kind_type ind_kind;
    logic ind_valid;
    logic req_stb;
    logic [7:0] req_octet;
    octet_port_pkg::octet_kind_type req_kind;
    logic req_valid;
    modport phy (output ind_stb, output ind_octet, output ind_kind, output ind_valid,
        input req_stb, input req_octet, input req_kind, input req_valid);
    modport dqdb (input ind_stb, input ind_octet, input ind_kind, input ind_valid,
        output req_stb, output req_octet, output req_kind, output req_valid);
endinterface

// file: verification/octet_sap_sva.sv
// Purpose: assertions on access point A of the octet port
// Assumes: one node clock, nrst active low
// Notes: relay timing across points is judged by the bench
`timescale 1ns/1ps
module octet_sap_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ind_stb,
    input wire logic [7:0] ind_octet,
    input var octet_port_pkg::octet_kind_type ind_kind,
    input wire logic ind_valid,
    input wire logic req_stb,
    input wire logic [7:0] req_octet,
    input var octet_port_pkg::octet_kind_type req_kind,
    input wire logic req_valid
);
    // ------------------------------------------------------------
    // slot length counters
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [5:0] ind_cnt_r;
    logic [5:0] req_cnt_r;
    wire logic ind_start = ind_stb && ind_kind == octet_port_pkg::OCT_SLOT_START;
    wire logic ind_data = ind_stb && ind_kind == octet_port_pkg::OCT_SLOT_DATA;
    wire logic req_start = req_stb && req_kind == octet_port_pkg::OCT_SLOT_START;
    wire logic req_data = req_stb && req_kind == octet_port_pkg::OCT_SLOT_DATA;
    wire logic [10:0] req_fields = {req_octet, req_kind, req_valid};
    sequence s_ind_data; ind_data; endsequence
    sequence s_req_data; req_data; endsequence
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ind_cnt_r <= 6'h00;
            req_cnt_r <= 6'h00;
        end else begin
            ind_cnt_r <= ind_start ? 6'h00 : ind_cnt_r + {5'h00, ind_data};
            req_cnt_r <= req_start ? 6'h00 : req_cnt_r + {5'h00, req_data};
        end
    end
    a_ind_octet_stands: assert property (!ind_stb |-> $stable(ind_octet))
        else $error("indication octet changed without strobe");
    a_ind_tag_stands: assert property (!ind_stb |-> $stable({ind_kind, ind_valid}))
        else $error("indication tag changed without strobe");
    a_req_fields_stand: assert property (!req_stb |-> $stable(req_fields))
        else $error("request fields changed without strobe");
    a_ind_kind_legal: assert property (ind_stb |-> ind_kind != 2'h3)
        else $error("indication kind out of range");
    a_req_kind_legal: assert property (req_stb |-> req_kind != 2'h3)
        else $error("request kind out of range");
    a_ind_slot_len: assert property (s_ind_data |-> ind_cnt_r < 6'h34)
        else $error("indication slot longer than start plus 52");
    a_req_slot_len: assert property (s_req_data |-> req_cnt_r < 6'h34)
        else $error("request slot longer than start plus 52");
    a_release_quiet: assert property ($rose(nrst) |-> !ind_stb && !req_stb)
        else $error("strobe on first edge after reset");
endmodule

// file: verification/testbench.sv
// Purpose: drives both ends of the octet port through link phases
// Assumes: frame shortened to 600 cycles, octet gap 2
// Notes: checks are muted for a few cycles after link changes (sync delay)
`timescale 1ns/1ps
`include "octet_port_defines.svh"
module testbench;
    // ------------------------------------------------------------
    // stimulus, model and checks
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hob = 1'b1;
    logic [1:0] link_up = 2'b10;
    logic [1:0] rx_stb = 2'h0;
    logic [15:0] rx_octet = 16'h0000;
    logic [3:0] rx_kind = 4'h0;
    logic [1:0] rx_valid = 2'h0;
    logic [15:0] set_mask = 16'h0000;
    logic [1:0] tx_stb, tx_valid, tx_dropped, rx_seen, slot_err;
    logic [15:0] tx_octet;
    logic [3:0] tx_kind;
    logic [11:0] r1 [2], s1 [2], s2 [2];
    logic err1 [2];
    integer seed = 32'h77b3;
    int miscompares = 0;
    int num_checks = 0;
    int quiet = 20;
    int cycles = 0;
    int empties = 0;
    int pos [2] = '{0, 0};
    int len [2] = '{53, 53};
    int cnt [2] = '{0, 0};
    localparam int FRAME = 600;
    localparam int GAP = 2;
    // frame position of the pacers before this edge, and before the last one
    int fr = 0;
    int fr1 = 0;
    octet_sap_if if_a ();
    octet_sap_if if_b ();
    wire logic [11:0] ind_a = {if_a.ind_stb, if_a.ind_octet, if_a.ind_kind, if_a.ind_valid};
    wire logic [11:0] ind_b = {if_b.ind_stb, if_b.ind_octet, if_b.ind_kind, if_b.ind_valid};
    octet_phy_end #(.FRAME_CYCLES(FRAME), .GAP(GAP)) octet_phy_end_inst (.clk(clk), .nrst(nrst),
        .sap_a(if_a), .sap_b(if_b), .hob_capable(hob), .link_up(link_up), .rx_stb(rx_stb),
        .rx_octet(rx_octet), .rx_kind(rx_kind), .rx_valid(rx_valid), .tx_stb(tx_stb),
        .tx_octet(tx_octet), .tx_kind(tx_kind), .tx_valid(tx_valid), .tx_dropped(tx_dropped));
    octet_dqdb_end octet_dqdb_end_inst (.clk(clk), .nrst(nrst), .sap_a(if_a), .sap_b(if_b),
        .set_mask(set_mask), .rx_seen(rx_seen), .slot_err(slot_err));
    octet_sap_sva octet_sap_sva_inst (.clk(clk), .nrst(nrst), .ind_stb(if_a.ind_stb),
        .ind_octet(if_a.ind_octet), .ind_kind(if_a.ind_kind), .ind_valid(if_a.ind_valid),
        .req_stb(if_a.req_stb), .req_octet(if_a.req_octet), .req_kind(if_a.req_kind),
        .req_valid(if_a.req_valid));
    always #2.5 clk = ~clk;
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // slot octets gain the mask bits, management is copied, down slots drop
    function automatic logic [12:0] tx_exp(input logic [11:0] s, input int o);
        logic slot;
        slot = s[2:1] != 2'h2;
        if (!s[11]) return 13'h0000;
        if (slot && !link_up[o]) return 13'h0800;
        return {2'b10, slot ? s[10:3] | set_mask[8*o +: 8] : s[10:3], s[2:0]};
    endfunction
    // local empties: one every GAP cycles, management first in a frame, then slots, the last one cut short at frame end
    function automatic logic [12:0] empty_exp(input int f);
        int t;
        logic [1:0] k;
        if (f % GAP != GAP - 1 || f == FRAME - 1) return 13'h0000;
        t = f / GAP - `MGMT_PER_FRAME;
        k = t < 0 ? 2'h2 : (t % (`SLOT_DATA_COUNT + 1) == 0 ? 2'h0 : 2'h1);
        return {2'b01, `EMPTY_OCTET, k, 1'b1};
    endfunction
    always @(posedge clk) begin
        logic [11:0] cm;
        logic [12:0] tv;
        int o;
        for (int i = 0; i < 2; i++) begin
            o = 1 - i;
            cm = (i == 0) ? ind_a : ind_b;
            cm = cm[11] ? cm : 12'h000;
            if (quiet == 0 && nrst) begin
                if (link_up[i]) check({1'b0, cm}, {1'b0, r1[i]});
                else if (!hob) check({1'b0, cm}, 13'h0000);
                else check({1'b0, cm}, empty_exp(fr1));
                tv = {tx_stb[o], tx_dropped[o], tx_stb[o] ? {tx_octet[8*o +: 8],
                    tx_kind[2*o +: 2], tx_valid[o]} : 11'h000};
                check(tv, tx_exp(s2[i], o));
                check({11'h000, rx_seen[o], slot_err[o]}, {11'h000, s1[i][11], err1[i]});
            end
            empties += (!link_up[i] && cm[11]) ? 1 : 0;
            s2[i] = nrst ? s1[i] : 12'h000;
            s1[i] = cm;
            err1[i] = cm[11] && cm[2:1] == 2'h0 && cnt[i] != 52;
            cnt[i] = !nrst || (cm[11] && cm[2:1] == 2'h0) ? 0 : cnt[i] + (cm[11] && cm[2:1] == 2'h1);
            r1[i] = (link_up[i] && rx_stb[i]) ?
                {1'b1, rx_octet[8*i +: 8], rx_kind[2*i +: 2], rx_valid[i]} : 12'h000;
        end
        fr1 = fr;
        fr = nrst ? (fr + 1) % FRAME : 0;
        // the link synchronisers restart after any reset, so checks wait again
        if (!nrst) quiet = 12;
        else if (quiet > 0) quiet--;
        if (++cycles > 8000) begin
            miscompares++;
            print_verdict();
        end
    end
    // random octets in whole slots, a short slot now and then, management between
    task automatic phase(input logic h, input logic [1:0] up, input int n);
        logic mg;
        @(negedge clk);
        hob = h;
        link_up = up;
        set_mask = 16'($random(seed));
        quiet = 12;
        pos = '{0, 0};
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 2; i++) begin
                if (pos[i] == 0) len[i] = ($random(seed) & 7) == 0 ? 52 : 53;
                mg = ($random(seed) & 15) == 0;
                rx_stb[i] = quiet == 0 && ($random(seed) & 1);
                rx_octet[8*i +: 8] = 8'($random(seed));
                rx_kind[2*i +: 2] = mg ? 2'h2 : (pos[i] == 0 ? 2'h0 : 2'h1);
                rx_valid[i] = 1'($random(seed));
                if (rx_stb[i] && !mg) pos[i] = (pos[i] + 1) % len[i];
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        phase(1'b1, 2'b10, 1300);
        phase(1'b1, 2'b11, 1500);
        @(negedge clk) nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        phase(1'b0, 2'b01, 1200);
        check({12'h000, empties != 0}, 13'h0001);
        print_verdict();
    end
endmodule
